// *** design/pcb_bridge.sv ***
`timescale 1ns/1ps
`include "pcb_defs.svh"
// Contract
// - All bus signals are sampled and driven on the single bus clock.
// - Reset forces every state machine, and every output except wrData (read from unreset FIFO memory), to a defined state.
// - Shared lines carry the 32-bit address, then data words.
// - Command/byte-enable lines give command, then per-lane enables, bit 0 is byte 0.
// - Read data phases drive even parity over data and byte enables.
// - Device select is asserted only when the address decodes to this target.
// - Configuration accesses are answered only while init-select is asserted.
// - A data phase completes when initiator and target ready are both asserted.
// - Target ready only with valid read data or room for write data; in a write burst trdy follows FIFO ready from before that cycle's push.
// - The device may assert stop; the master must then end the transaction.
// - A write data parity error pulses the data parity error output.
// - An address parity error pulses the system error output.
// - Battery inputs: both high good, second low weak, first low failed.
// - For I/O cards the first battery input is a status-change indication.
// - Slot audio is taken only in I/O mode and merged onto the speaker.
// - Each slot drives a 26-bit card address, highest line most significant.
// - For modem cards the first battery input is a ring indication.
// - A card is present when both detect inputs are low; state is readable.
// - In memory-only mode a low ready/busy means busy, high means ready.
module pcb_bridge
    import pcb_pkg::*;
#(
    parameter int FIFO_DEPTH = `PCB_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Bus address/data and parity, three signals per two-way pin.
    input wire logic [31:0] adIn,
    output logic [31:0] adOut,
    output logic adOe_n,
    input wire logic [3:0] cbeIn_n,
    input wire logic parIn,
    output logic parOut,
    output logic parOe_n,
    // Bus control, active low apart from idsel.
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic idsel,
    output logic devsel_n,
    output logic trdy_n,
    output logic stop_n,
    output logic ctlOe_n,
    output logic perr_n,
    output logic perrOe_n,
    output logic serr_n,
    output logic serrOe_n,
    // Slot configuration from the socket controller.
    input wire logic [1:0] slotIoMode,
    input wire logic [1:0] slotModem,
    // Slot inputs.
    input wire logic [1:0] bvd1,
    input wire logic [1:0] bvd2,
    input wire logic [1:0] cd1_n,
    input wire logic [1:0] cd2_n,
    input wire logic [1:0] rdyBsy,
    // Slot outputs.
    output logic [`PCB_CA_W-1:0] cardAddrA,
    output logic [`PCB_CA_W-1:0] cardAddrB,
    output logic [1:0] cardPresent,
    output logic [1:0] cardBusy,
    output logic [3:0] batteryState,
    output logic [1:0] statusChange,
    output logic [1:0] ringIndicate,
    output logic speaker_out,
    // Written words towards the card side.
    output logic wrValid,
    input wire logic wrReady,
    output logic [63:0] wrData
);
    typedef struct packed
    {
        pcb_state_e state;
        logic [31:0] addr;
        logic [3:0] cmd;
        logic isWrite;
        logic isCfg;
        logic [31:0] adOut;
        logic adOe;
        logic parOut;
        logic parOe;
        logic devsel;
        logic trdy;
        logic stop;
        logic ctlOe;
        logic chkAddr;
        logic chkData;
        logic [31:0] chkAd;
        logic [3:0] chkCbe;
        logic perr;
        logic perrOe;
        logic serr;
        logic serrOe;
        logic [`PCB_CA_W-1:0] caA;
        logic [`PCB_CA_W-1:0] caB;
        logic [1:0] present;
        logic [1:0] busy;
        logic [3:0] bat;
        logic [1:0] stsChg;
        logic [1:0] ring;
        logic spk;
    } pcb_bridge_s;
    pcb_bridge_s st_r;
    pcb_bridge_s st_nxt;
    // Slot pins are asynchronous to the bus clock; two stages each.
    logic [11:0] pinMeta_r;
    logic [11:0] pinSync_r;
    logic [3:0] cmdIn;
    logic hit;
    logic cmdRd;
    logic cmdWr;
    logic fifoInReady;
    logic fifoPush;
    logic [31:0] rdWord;
    assign cmdIn = cbeIn_n;
    assign cmdRd = cmdIn == `PCB_CMD_MEMRD || cmdIn == `PCB_CMD_IORD || cmdIn == `PCB_CMD_CFGRD;
    assign cmdWr = cmdIn == `PCB_CMD_MEMWR || cmdIn == `PCB_CMD_IOWR || cmdIn == `PCB_CMD_CFGWR;
    // Memory and I/O decode a fixed window; configuration needs init-select.
    always_comb
    begin
        hit = 1'b0;
        if (cmdIn == `PCB_CMD_CFGRD || cmdIn == `PCB_CMD_CFGWR)
        begin
            hit = idsel;
        end
        else if (cmdRd || cmdWr)
        begin
            hit = adIn[31:`PCB_WIN_SHIFT] == `PCB_WIN_BASE;
        end
    end
    assign rdWord = st_r.isCfg ? `PCB_CFG_ID : {6'h00, st_r.present, st_r.busy, st_r.bat, st_r.stsChg,
        st_r.ring, 14'h0000};
    assign fifoPush = st_r.state == PCB_DATA && st_r.isWrite && st_r.trdy && !irdy_n;
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
        end
        else
        begin
            pinMeta_r <= {bvd1, bvd2, cd1_n, cd2_n, rdyBsy, slotIoMode & 2'b11};
            pinSync_r <= pinMeta_r;
        end
    end
    always_comb
    begin
        logic [1:0] sB1;
        logic [1:0] sB2;
        logic [1:0] sC1;
        logic [1:0] sC2;
        logic [1:0] sRb;
        sB1 = pinSync_r[11:10];
        sB2 = pinSync_r[9:8];
        sC1 = pinSync_r[7:6];
        sC2 = pinSync_r[5:4];
        sRb = pinSync_r[3:2];
        st_nxt = st_r;
        st_nxt.chkAddr = 1'b0;
        st_nxt.chkData = 1'b0;
        st_nxt.perr = 1'b0;
        st_nxt.serr = 1'b0;
        st_nxt.perrOe = 1'b0;
        st_nxt.serrOe = 1'b0;
        // Parity arrives one clock after the phase it covers.
        if (st_r.chkAddr && ((^st_r.chkAd) ^ (^st_r.chkCbe) ^ parIn))
        begin
            st_nxt.serr = 1'b1;
            st_nxt.serrOe = 1'b1;
        end
        if (st_r.chkData && ((^st_r.chkAd) ^ (^st_r.chkCbe) ^ parIn))
        begin
            st_nxt.perr = 1'b1;
            st_nxt.perrOe = 1'b1;
        end
        // Read parity lags the data by one clock, as the bus requires.
        st_nxt.parOe = st_r.adOe;
        st_nxt.parOut = (^st_r.adOut) ^ (^cbeIn_n);
        unique case (st_r.state)
            PCB_IDLE:
            begin
                if (!frame_n)
                begin
                    st_nxt.chkAddr = 1'b1;
                    st_nxt.chkAd = adIn;
                    st_nxt.chkCbe = cbeIn_n;
                    if (hit)
                    begin
                        st_nxt.addr = adIn;
                        st_nxt.cmd = cmdIn;
                        st_nxt.isWrite = cmdWr;
                        st_nxt.isCfg = !(cmdRd || cmdWr) || cmdIn == `PCB_CMD_CFGRD || cmdIn == `PCB_CMD_CFGWR;
                        st_nxt.state = PCB_ADDR;
                    end
                end
            end
            PCB_ADDR:
            begin
                st_nxt.devsel = 1'b1;
                st_nxt.ctlOe = 1'b1;
                st_nxt.state = PCB_DATA;
                if (!st_r.isWrite)
                begin
                    st_nxt.adOut = rdWord;
                    st_nxt.adOe = 1'b1;
                    st_nxt.trdy = 1'b1;
                end
                else
                begin
                    st_nxt.trdy = fifoInReady;
                end
            end
            PCB_DATA:
            begin
                if (st_r.trdy && !irdy_n)
                begin
                    if (st_r.isWrite)
                    begin
                        st_nxt.chkData = 1'b1;
                        st_nxt.chkAd = adIn;
                        st_nxt.chkCbe = cbeIn_n;
                    end
                    if (frame_n)
                    begin
                        st_nxt.state = PCB_TURN;
                        st_nxt.devsel = 1'b0;
                        st_nxt.trdy = 1'b0;
                        st_nxt.stop = 1'b0;
                        st_nxt.adOe = 1'b0;
                    end
                    else if (!st_r.isWrite)
                    begin
                        // Single-word reads: disconnect after the first word.
                        st_nxt.trdy = 1'b0;
                        st_nxt.stop = 1'b1;
                    end
                    else
                    begin
                        st_nxt.trdy = fifoInReady;
                    end
                end
                else if (st_r.isWrite && !st_r.trdy)
                begin
                    st_nxt.trdy = fifoInReady;
                end
                else if (st_r.stop && frame_n)
                begin
                    st_nxt.state = PCB_TURN;
                    st_nxt.devsel = 1'b0;
                    st_nxt.stop = 1'b0;
                    st_nxt.adOe = 1'b0;
                end
            end
            PCB_TURN:
            begin
                st_nxt.ctlOe = 1'b0;
                st_nxt.state = PCB_IDLE;
            end
            default:
            begin
                st_nxt.state = PCB_IDLE;
            end
        endcase
        // Card address of the slot chosen by address bit 23 follows the last accepted bus address.
        if (st_r.state == PCB_ADDR)
        begin
            if (st_r.addr[`PCB_SLOT_BIT])
            begin
                st_nxt.caB = st_r.addr[`PCB_CA_W-1:0];
            end
            else
            begin
                st_nxt.caA = st_r.addr[`PCB_CA_W-1:0];
            end
        end
        for (int s = 0; s < 2; s++)
        begin
            st_nxt.present[s] = !sC1[s] && !sC2[s];
            st_nxt.busy[s] = !pinSync_r[s] && !sRb[s];
            if (!sB1[s])
            begin
                st_nxt.bat[2*s +: 2] = PCB_BAT_FAIL;
            end
            else if (!sB2[s])
            begin
                st_nxt.bat[2*s +: 2] = PCB_BAT_WEAK;
            end
            else
            begin
                st_nxt.bat[2*s +: 2] = PCB_BAT_GOOD;
            end
            st_nxt.stsChg[s] = pinSync_r[s] && !slotModem[s] && !sB1[s];
            st_nxt.ring[s] = pinSync_r[s] && slotModem[s] && !sB1[s];
        end
        st_nxt.spk = (pinSync_r[0] && sB2[0]) ^ (pinSync_r[1] && sB2[1]);
    end
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.state <= PCB_IDLE;
            st_r.bat <= 4'h0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    // Written words pair with their address and byte enables in the FIFO.
    pcb_fifo #(
        .WIDTH(64),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .inData({st_r.addr[31:4], ~cbeIn_n, adIn}),
        .outValid(wrValid),
        .outReady(wrReady),
        .outData(wrData)
    );
    assign adOut = st_r.adOut;
    assign adOe_n = !st_r.adOe;
    assign parOut = st_r.parOut;
    assign parOe_n = !st_r.parOe;
    assign devsel_n = !st_r.devsel;
    assign trdy_n = !st_r.trdy;
    assign stop_n = !st_r.stop;
    assign ctlOe_n = !st_r.ctlOe;
    assign perr_n = !st_r.perr;
    assign perrOe_n = !st_r.perrOe;
    assign serr_n = !st_r.serr;
    assign serrOe_n = !st_r.serrOe;
    assign cardAddrA = st_r.caA;
    assign cardAddrB = st_r.caB;
    assign cardPresent = st_r.present;
    assign cardBusy = st_r.busy;
    assign batteryState = st_r.bat;
    assign statusChange = st_r.stsChg;
    assign ringIndicate = st_r.ring;
    assign speaker_out = st_r.spk;
endmodule

// *** design/pcb_defs.svh ***
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH
`define PCB_CMD_MEMRD 4'h6
`define PCB_CMD_MEMWR 4'h7
`define PCB_CMD_CFGRD 4'hA
`define PCB_CMD_CFGWR 4'hB
`define PCB_CMD_IORD 4'h2
`define PCB_CMD_IOWR 4'h3
`define PCB_WIN_SHIFT 24
`define PCB_WIN_BASE 8'h0C
// Slot select sits inside the decode window, so memory and I/O accesses reach both slots.
`define PCB_SLOT_BIT 23
`define PCB_CA_W 26
`define PCB_FIFO_DEPTH 16
// Arbitrary value; it names no real part.
`define PCB_CFG_ID 32'h1234_5678
`endif

// *** design/pcb_fifo.sv ***
`timescale 1ns/1ps
module pcb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Fill side.
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side.
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed
    {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
    } pcb_fifo_s;
    pcb_fifo_s st_r;
    pcb_fifo_s st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;
    assign inReady = st_r.count != (AW+1)'(DEPTH);
    assign outValid = st_r.count != '0;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[st_r.rdPtr];
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.wrPtr = st_r.wrPtr + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rdPtr = st_r.rdPtr + 1'b1;
        end
        st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
        if (push)
        begin
            mem[st_r.wrPtr] <= inData;
        end
    end
endmodule

// *** design/pcb_pkg.sv ***
package pcb_pkg;
    typedef enum logic [3:0]
    {
        PCB_IDLE = 4'b0001,
        PCB_ADDR = 4'b0010,
        PCB_DATA = 4'b0100,
        PCB_TURN = 4'b1000
    } pcb_state_e;
    typedef enum logic [1:0]
    {
        PCB_BAT_GOOD = 2'b00,
        PCB_BAT_WEAK = 2'b01,
        PCB_BAT_FAIL = 2'b10
    } pcb_bat_e;
endpackage

// *** verif/pcb_bridge_assertions.sv ***
`timescale 1ns/1ps
`include "pcb_defs.svh"
module pcb_bridge_assertions
    import pcb_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Bus side.
    input wire logic [31:0] adIn,
    input wire logic [31:0] adOut,
    input wire logic adOe_n,
    input wire logic [3:0] cbeIn_n,
    input wire logic parIn,
    input wire logic parOut,
    input wire logic parOe_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic idsel,
    input wire logic devsel_n,
    input wire logic trdy_n,
    input wire logic stop_n,
    input wire logic ctlOe_n,
    input wire logic perr_n,
    input wire logic perrOe_n,
    input wire logic serr_n,
    // Slot side.
    input wire logic [1:0] slotIoMode,
    input wire logic [1:0] bvd1,
    input wire logic [1:0] bvd2,
    input wire logic [1:0] cd1_n,
    input wire logic [1:0] cd2_n,
    input wire logic [1:0] cardPresent,
    input wire logic [3:0] batteryState,
    input wire logic speaker_out
);
    logic hit;
    logic frameQ;
    logic start;
    // Reset parks the frame copy high so no start is seen from stale values.
    always_ff @(posedge clk_sys)
        frameQ <= reset | frame_n;
    assign start = frameQ & ~frame_n;
    assign hit = ((cbeIn_n inside {`PCB_CMD_IORD, `PCB_CMD_IOWR, `PCB_CMD_MEMRD, `PCB_CMD_MEMWR})
        && adIn[31:24] == `PCB_WIN_BASE) || (cbeIn_n[3:1] == 3'b101 && idsel);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    a_reset_quiet: assert property (disable iff (1'b0) reset |=>
        devsel_n && trdy_n && stop_n && adOe_n && parOe_n && perr_n && serr_n)
        else $error("outputs active after reset");
    a_hit_select: assert property (start && hit |-> ##2 !devsel_n && !ctlOe_n)
        else $error("claimed access not selected");
    a_miss_quiet: assert property (start && !hit |-> ##1 devsel_n [*3])
        else $error("unclaimed access selected");
    a_trdy_select: assert property (!trdy_n |-> !devsel_n)
        else $error("target ready without select");
    a_stop_select: assert property (!stop_n |-> !devsel_n && trdy_n)
        else $error("stop without select or with target ready");
    a_read_parity: assert property (!parOe_n |-> parOut == ^{$past(adOut), $past(cbeIn_n)})
        else $error("read parity wrong");
    a_perr_write: assert property ($past(!irdy_n && !trdy_n && adOe_n)
        && parIn != ^{$past(adIn), $past(cbeIn_n)} |-> ##1 !perr_n && !perrOe_n)
        else $error("write parity error not flagged");
    a_perr_pulse: assert property (!perr_n |=> perr_n)
        else $error("parity error pulse too long");
    a_serr_addr: assert property ($past(start) && parIn != ^{$past(adIn), $past(cbeIn_n)}
        |-> ##1 !serr_n) else $error("address parity error not flagged");
    a_speaker_mute: assert property ((slotIoMode == 2'b00) [*5] |-> !speaker_out)
        else $error("speaker active outside io mode");
    a_battery_weak: assert property ((bvd1[0] && !bvd2[0]) [*6] |-> batteryState[1:0] == PCB_BAT_WEAK)
        else $error("weak battery not reported");
    a_detect_gone: assert property ((cd1_n[1] || cd2_n[1]) [*6] |-> !cardPresent[1])
        else $error("absent card reported present");
endmodule
bind pcb_bridge pcb_bridge_assertions pcb_bridge_assertions_i (.clk_sys, .reset, .adIn, .adOut, .adOe_n,
    .cbeIn_n, .parIn, .parOut, .parOe_n, .frame_n, .irdy_n, .idsel, .devsel_n, .trdy_n, .stop_n, .ctlOe_n,
    .perr_n, .perrOe_n, .serr_n, .slotIoMode, .bvd1, .bvd2, .cd1_n, .cd2_n, .cardPresent, .batteryState,
    .speaker_out);

// *** verif/pcb_master.sv ***
`timescale 1ns/1ps
module pcb_master (
    // Clock.
    input wire logic clk_sys,
    // Bus as seen on the wires.
    input wire logic [31:0] adBus,
    input wire logic devsel_n,
    input wire logic trdy_n,
    input wire logic stop_n,
    // Initiator drives.
    output logic [31:0] mAd,
    output logic [3:0] mCbe_n,
    output logic mPar,
    output logic frame_n,
    output logic irdy_n
);
    logic hit;
    logic [31:0] rdData;
    logic stopped;
    initial
    begin
        {mAd, mCbe_n, mPar, frame_n, irdy_n, hit, stopped} = {32'h0, 4'hF, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    end
    // Single data phase; badA corrupts the address parity, badD that of the data phase.
    task automatic cyc(input logic [3:0] cmd, input logic [31:0] addr, dat, input logic [3:0] be_n,
        input logic badA, badD);
        int n;
        @(negedge clk_sys);
        frame_n = 0;
        mAd = addr;
        mCbe_n = cmd;
        @(negedge clk_sys);
        frame_n = 1;
        irdy_n = 0;
        mPar = ^{addr, cmd} ^ badA;
        mAd = cmd[0] ? dat : ~addr;
        mCbe_n = be_n;
        n = 0;
        // Give up as an abort when nobody claims the access.
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (trdy_n && n < 200 && !(n > 5 && devsel_n));
        hit = !trdy_n;
        rdData = adBus;
        @(negedge clk_sys);
        irdy_n = 1;
        mPar = ^{dat, be_n} ^ badD;
        mAd = ~mAd;
        @(negedge clk_sys);
        mPar = ~mPar;
    endtask
    // Burst read: frame stays low until the target asks to stop.
    task automatic rdStop(input logic [3:0] cmd, input logic [31:0] addr);
        int n;
        @(negedge clk_sys);
        frame_n = 0;
        mAd = addr;
        mCbe_n = cmd;
        @(negedge clk_sys);
        irdy_n = 0;
        mPar = ^{addr, cmd};
        mAd = ~addr;
        mCbe_n = 4'h0;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (trdy_n && n < 20);
        rdData = adBus;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (stop_n && n < 20);
        stopped = !stop_n;
        @(negedge clk_sys);
        frame_n = 1;
        @(negedge clk_sys);
        irdy_n = 1;
    endtask
endmodule

// *** verif/pci_target_card_bridge_tb.sv ***
`timescale 1ns/1ps
`include "pcb_defs.svh"
module pci_target_card_bridge_tb
    import pcb_pkg::*;
;
    logic clk_sys, reset, idsel, wrReady, speaker_out, wrValid, frame_n, irdy_n, mPar;
    logic adOe_n, parOut, parOe_n, devsel_n, trdy_n, stop_n, ctlOe_n, perr_n, perrOe_n, serr_n, serrOe_n;
    logic [31:0] adOut, mAd;
    logic [3:0] mCbe_n, batteryState;
    logic [1:0] slotIoMode, slotModem, bvd1, bvd2, cd1_n, cd2_n, rdyBsy;
    logic [1:0] cardPresent, cardBusy, statusChange, ringIndicate;
    logic [25:0] cardAddrA, cardAddrB;
    logic [63:0] wrData, lastWr;
    logic perrSeen = 0;
    logic serrSeen = 0;
    int errTotal = 0;
    int samplesChecked = 0;
    int nWr = 0;
    wire [31:0] adIn = adOe_n ? mAd : adOut;
    wire parIn = parOe_n ? mPar : parOut;
    pcb_bridge pcb_bridge_i (.clk_sys, .reset, .adIn, .adOut, .adOe_n, .cbeIn_n(mCbe_n), .parIn, .parOut,
        .parOe_n, .frame_n, .irdy_n, .idsel, .devsel_n, .trdy_n, .stop_n, .ctlOe_n, .perr_n, .perrOe_n,
        .serr_n, .serrOe_n, .slotIoMode, .slotModem, .bvd1, .bvd2, .cd1_n, .cd2_n, .rdyBsy, .cardAddrA,
        .cardAddrB, .cardPresent, .cardBusy, .batteryState, .statusChange, .ringIndicate, .speaker_out,
        .wrValid, .wrReady, .wrData);
    pcb_master pcb_master_i (.clk_sys, .adBus(adIn), .devsel_n, .trdy_n, .stop_n, .mAd, .mCbe_n, .mPar,
        .frame_n, .irdy_n);
    initial
    begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (perr_n === 1'b0 && perrOe_n === 1'b0)
            perrSeen <= 1;
        if (serr_n === 1'b0 && serrOe_n === 1'b0)
            serrSeen <= 1;
        if (wrValid === 1'b1 && wrReady)
        begin
            nWr <= nWr + 1;
            lastWr <= wrData;
        end
    end
    task automatic chk(input string what, input logic [63:0] got, exp);
        samplesChecked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic t_cmds;
        logic [3:0] c[4] = '{4'h2, 4'h3, 4'h6, 4'h7};
        foreach (c[i])
        begin
            pcb_master_i.cyc(c[i], 32'h0C00_0040 + i, 32'hA5A5_0F0F ^ i, 4'b0101, 0, 0);
            chk("hit", pcb_master_i.hit, 1);
            if (!c[i][0])
                chk("present", pcb_master_i.rdData[25:24], 2'b11);
        end
        repeat (4) @(negedge clk_sys);
        chk("written", lastWr, {28'h0C0_0004, 4'b1010, 32'hA5A5_0F0C});
        chk("cardaddr", cardAddrA, 26'h000_0043);
    endtask
    task automatic t_stop;
        pcb_master_i.rdStop(`PCB_CMD_MEMRD, 32'h0C80_0055);
        chk("stopped", pcb_master_i.stopped, 1);
        chk("burstword", pcb_master_i.rdData[25:24], 2'b11);
        chk("cardaddrB", cardAddrB, 26'h080_0055);
        chk("cardaddrA", cardAddrA, 26'h000_0043);
        repeat (2) @(negedge clk_sys);
        chk("released", {devsel_n, stop_n, ctlOe_n}, 3'b111);
    endtask
    task automatic t_cfg;
        idsel = 1;
        pcb_master_i.cyc(`PCB_CMD_CFGRD, 32'h0, 32'h0, 4'h0, 0, 0);
        chk("cfg", pcb_master_i.rdData, `PCB_CFG_ID);
        idsel = 0;
        pcb_master_i.cyc(`PCB_CMD_CFGRD, 32'h0, 32'h0, 4'h0, 0, 0);
        chk("cfgoff", pcb_master_i.hit, 0);
        pcb_master_i.cyc(`PCB_CMD_MEMRD, 32'h0D00_0000, 32'h0, 4'h0, 0, 0);
        chk("miss", pcb_master_i.hit, 0);
    endtask
    task automatic t_par;
        pcb_master_i.cyc(`PCB_CMD_MEMWR, 32'h0C00_0100, 32'h1, 4'h0, 0, 1);
        repeat (3) @(negedge clk_sys);
        chk("perr", perrSeen, 1);
        chk("serrquiet", serrSeen, 0);
        pcb_master_i.cyc(`PCB_CMD_MEMRD, 32'h0D00_0100, 32'h0, 4'h0, 1, 0);
        repeat (3) @(negedge clk_sys);
        chk("serr", serrSeen, 1);
    endtask
    task automatic t_full;
        int base;
        base = nWr;
        wrReady = 0;
        repeat (16) pcb_master_i.cyc(`PCB_CMD_MEMWR, 32'h0C00_0200, 32'h5, 4'h0, 0, 0);
        fork
            pcb_master_i.cyc(`PCB_CMD_MEMWR, 32'h0C00_0204, 32'h6, 4'h0, 0, 0);
            begin
                repeat (12) @(negedge clk_sys);
                chk("stall", trdy_n, 1);
                wrReady = 1;
            end
        join
        repeat (30) @(negedge clk_sys);
        chk("drained", nWr - base, 17);
    endtask
    task automatic t_pins;
        logic [1:0] bv[3] = '{2'b11, 2'b10, 2'b01};
        logic [1:0] st[3] = '{PCB_BAT_GOOD, PCB_BAT_WEAK, PCB_BAT_FAIL};
        for (int i = 0; i < 3; i++)
        begin
            @(negedge clk_sys);
            {bvd1[0], bvd2[0]} = bv[i];
            rdyBsy[0] = i[0];
            repeat (6) @(negedge clk_sys);
            chk("battery", batteryState[1:0], st[i]);
            chk("busy", cardBusy[0], !i[0]);
        end
        slotIoMode = 2'b11;
        slotModem = 2'b10;
        {bvd1, bvd2} = 4'b0001;
        cd1_n[1] = 1;
        repeat (6) @(negedge clk_sys);
        chk("stschg", statusChange[0], 1);
        chk("ring", ringIndicate[1], 1);
        chk("speaker", speaker_out, 1);
        chk("present1", cardPresent, 2'b01);
        bvd2 = 2'b11;
        repeat (6) @(negedge clk_sys);
        chk("speakermix", speaker_out, 0);
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        #200_000;
        errTotal++;
        summarize;
    end
    initial
    begin
        {reset, idsel, wrReady, slotIoMode, slotModem} = 7'h07 << 4;
        {bvd1, bvd2, rdyBsy} = '1;
        {cd1_n, cd2_n} = '0;
        repeat (2) @(negedge clk_sys);
        chk("idle", {devsel_n, trdy_n, stop_n, adOe_n, perr_n, serr_n}, 6'h3F);
        reset = 0;
        t_cmds;
        t_stop;
        t_cfg;
        t_par;
        t_full;
        t_pins;
        summarize;
    end
endmodule
